/* mrd_bus_if.sv */
// parallel register bus joining the host and the device
`timescale 1ns/1ps
interface mrd_bus_if;
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic ale;
  logic [7:0] addr;
  logic [7:0] data_h2d;
  logic data_h2d_oe;
  logic [7:0] data_d2h;
  logic data_d2h_oe;
  modport device (input chip_select_n, read_strobe_n, write_strobe_n, ale, addr, data_h2d,
    data_h2d_oe, output data_d2h, data_d2h_oe);
  modport host (output chip_select_n, read_strobe_n, write_strobe_n, ale, addr, data_h2d,
    data_h2d_oe, input data_d2h, data_d2h_oe);
endinterface

/* mrd_checker.sv */
// assertions on the parallel register bus and the device controls
`timescale 1ns/1ps
module mrd_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // parallel bus
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic data_h2d_oe,
  input wire logic data_d2h_oe,
  // device controls
  input wire logic core_reset_n,
  input wire logic standby,
  input wire logic counter_load
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rd_fall;
    $fell(read_strobe_n) && !chip_select_n;
  endsequence
  sequence s_wr_fall;
    $fell(write_strobe_n) && !chip_select_n;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_CS_IN_STROBE: assert property (!(read_strobe_n && write_strobe_n) |-> !chip_select_n)
    else $error("strobe active with chip select high");
  AST_CS_AT_WR_END: assert property ($rose(write_strobe_n) |-> !chip_select_n)
    else $error("chip select released before write strobe");
  AST_ONE_STROBE: assert property (!(!read_strobe_n && !write_strobe_n))
    else $error("read and write strobes low together");
  // the device syncs strobes through two flops, so short ones would be lost
  AST_RD_HELD: assert property (s_rd_fall |-> !read_strobe_n [*4])
    else $error("read strobe shorter than four cycles");
  AST_WR_HELD: assert property (s_wr_fall |-> !write_strobe_n [*4])
    else $error("write strobe shorter than four cycles");
  AST_RD_ANSWER: assert property (s_rd_fall |-> ##[2:4] data_d2h_oe)
    else $error("device did not drive read data");
  AST_NO_CLASH: assert property (!(data_d2h_oe && data_h2d_oe))
    else $error("both ends drive the data bus");
  AST_OE_SELECTED: assert property (data_d2h_oe |-> !chip_select_n)
    else $error("device drives data while not selected");
  AST_STANDBY_CORE: assert property (standby |-> !core_reset_n)
    else $error("core running during software reset");
  AST_LOAD_PULSE: assert property (counter_load |=> !counter_load)
    else $error("counter load longer than one cycle");
  AST_NO_LOAD_SWRST: assert property ($rose(standby) |-> !counter_load)
    else $error("counter load on a reset write");
  AST_HW_CLEARS: assert property ($rose(aresetn) |-> !standby && !counter_load)
    else $error("standby survives hardware reset");
endmodule

/* mrd_consts.svh */
// constants for the master register decode block
`ifndef MRD_CONSTS_SVH
`define MRD_CONSTS_SVH
`define MRD_A_TEST_BIT 7
`define MRD_OFF_MASTER 8'h00
`define MRD_OFF_CONFIG 8'h01
`define MRD_OFF_IRQSRC 8'h02
`define MRD_OFF_RATE 8'h03
`define MRD_OFF_CLKACT 8'h04
`define MRD_OFF_CONTROL 8'h05
`define MRD_OFF_SYNTH 8'h06
`define MRD_OFF_RECCTL 8'h08
`define MRD_OFF_RECCFG 8'h09
`define MRD_OFF_TXCFG 8'h0A
`define MRD_OFF_RXCFG 8'h0C
`define MRD_OFF_TEST 8'h80
`define MRD_BIT_RESET 7
`define MRD_BIT_TIP 3
// family and revision codes: arbitrary values
`define MRD_FAMILY 3'h5
`define MRD_REVISION 3'h2
`define MRD_CONFIG_RST 8'h71
`define MRD_RATE_RST 8'h03
`define MRD_XFER_CYCLES 4'h8
`define MRD_XFER_ONE 4'h1
`define MRD_XFER_ZERO 4'h0
`define MRD_PHASE 4'h6
`define MRD_CMD_READ 2'h1
`define MRD_CMD_WRITE 2'h2
`define MRD_AXI_CMD 4'h0
`define MRD_AXI_ADDR 4'h4
`define MRD_AXI_WDATA 4'h8
`define MRD_AXI_STATUS 4'hC
`endif

/* mrd_device.sv */
// device end: register decode, master reset, identity and counter load
`timescale 1ns/1ps
`include "mrd_consts.svh"
// What this block does
// - host holds chip select low per access
// - address bit seven selects test registers
// - unused bits ignore writes, read anything
// - host writes zero into unused bits
// - writable bits read back last value
// - writable bits reset to zero unless stated
// - writes to read-only bits change nothing
// - host honours reserved bits and addresses
// - master register field layout at zero
// - write without reset loads all counters
// - transfer flag high while load runs
// - host may poll transfer flag
// - reset bit holds device in reset
// - software reset means low-power standby
// - hardware reset clears reset bit
// - revision code reads binary revision
// - family code reads fixed value
// - eight-bit data and address bus
module mrd_device
  import mrd_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  mrd_bus_if.device bus,
  // device-wide controls
  output logic core_reset_n,
  output logic standby,
  output logic counter_load,
  output logic [7:0] config_q,
  output logic [1:0] rate_q
);
  logic [1:0] cs_s;
  logic [2:0] rd_s;
  logic [2:0] wr_s;
  logic [1:0] ale_s;
  logic [7:0] addr_m;
  logic [7:0] addr_s;
  logic [7:0] addr_l;
  logic [7:0] din_m;
  logic [7:0] din_s;
  logic soft_reset;
  logic [3:0] xfer_count;
  logic [7:0] config_r;
  logic [7:0] rate_r;
  logic [7:0] rxcfg_r;
  logic [7:0] txcfg_r;
  logic [7:0] test_r;
  logic wr_pulse;
  logic rd_pulse;
  logic [7:0] next_rdata;
  logic soft_pulse;
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    cs_s <= {cs_s[0], bus.chip_select_n};
    rd_s <= {rd_s[1], rd_s[0], bus.read_strobe_n};
    wr_s <= {wr_s[1], wr_s[0], bus.write_strobe_n};
    ale_s <= {ale_s[0], bus.ale};
    addr_m <= bus.addr;
    addr_s <= addr_m;
    din_m <= bus.data_h2d;
    din_s <= din_m;
  end
  // address followed while synced ale is high; both come through two flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      addr_l <= 8'h00;
    else if (ale_s[1])
      addr_l <= addr_s;
  end
  // strobes count only with chip select low
  assign wr_pulse = !cs_s[1] && wr_s[2] && !wr_s[1];
  assign rd_pulse = !cs_s[1] && rd_s[2] && !rd_s[1];
  assign soft_pulse = wr_pulse && addr_l == `MRD_OFF_MASTER && din_s[`MRD_BIT_RESET];
  //////////////////////////////////////////////////////////////////////////////
  // software reset bit; only hardware reset clears it implicitly
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      soft_reset <= 1'b0;
    else if (wr_pulse && addr_l == `MRD_OFF_MASTER)
      soft_reset <= din_s[`MRD_BIT_RESET];
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_reset_n <= 1'b0;
      standby <= 1'b0;
    end
    else
    begin
      core_reset_n <= !soft_reset && !soft_pulse;
      standby <= soft_reset;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // counter load transfer; a load write during a transfer restarts it
  // the releasing write also loads, so it wins over the held reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xfer_count <= `MRD_XFER_ZERO;
      counter_load <= 1'b0;
    end
    else if (wr_pulse && addr_l == `MRD_OFF_MASTER && !din_s[`MRD_BIT_RESET])
    begin
      xfer_count <= `MRD_XFER_CYCLES;
      counter_load <= 1'b1;
    end
    else if (soft_reset)
    begin
      xfer_count <= `MRD_XFER_ZERO;
      counter_load <= 1'b0;
    end
    else
    begin
      counter_load <= 1'b0;
      if (xfer_count != `MRD_XFER_ZERO)
        xfer_count <= xfer_count - `MRD_XFER_ONE;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // writable registers; software reset acts as hardware reset, port stays alive
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset)
    begin
      config_r <= `MRD_CONFIG_RST;
      rate_r <= `MRD_RATE_RST;
      txcfg_r <= 8'h00;
      rxcfg_r <= 8'h00;
      test_r <= 8'h00;
    end
    else if (wr_pulse)
    begin
      if (addr_l[`MRD_A_TEST_BIT])
      begin
        if (addr_l == `MRD_OFF_TEST)
          test_r <= din_s;
      end
      else
      begin
        case (addr_l)
          `MRD_OFF_CONFIG: config_r <= din_s & 8'h7F;
          `MRD_OFF_RATE: rate_r <= din_s & 8'h03;
          `MRD_OFF_TXCFG: txcfg_r <= din_s;
          `MRD_OFF_RXCFG: rxcfg_r <= din_s;
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      config_q <= 8'h00;
      rate_q <= 2'h0;
    end
    else
    begin
      config_q <= config_r;
      rate_q <= rate_r[1:0];
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (addr_l[`MRD_A_TEST_BIT])
    begin
      if (addr_l == `MRD_OFF_TEST)
        next_rdata = test_r;
    end
    else
    begin
      case (addr_l)
        `MRD_OFF_MASTER: next_rdata = {soft_reset, `MRD_FAMILY,
          xfer_count != `MRD_XFER_ZERO, `MRD_REVISION};
        `MRD_OFF_CONFIG: next_rdata = config_r;
        `MRD_OFF_RATE: next_rdata = rate_r;
        `MRD_OFF_TXCFG: next_rdata = txcfg_r;
        `MRD_OFF_RXCFG: next_rdata = rxcfg_r;
        default: next_rdata = 8'h00;
      endcase
    end
  end
  // data driven while read strobe and chip select are low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus.data_d2h <= 8'h00;
      bus.data_d2h_oe <= 1'b0;
    end
    else
    begin
      if (rd_pulse)
        bus.data_d2h <= next_rdata;
      bus.data_d2h_oe <= !cs_s[1] && !rd_s[1];
    end
  end
endmodule

/* mrd_host.sv */
// host end: AXI4-Lite command registers driving the parallel bus
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mrd_consts.svh"
module mrd_host
  import mrd_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // parallel bus
  mrd_bus_if.host bus
);
  localparam logic [3:0] PHASE = `MRD_PHASE;
  mrd_host_state_t state;
  logic [3:0] tick;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic is_write;
  logic busy;
  logic aw_got;
  logic w_got;
  logic [31:0] aw_q;
  logic [31:0] w_q;
  logic [31:0] next_rdata;
  logic go;
  //////////////////////////////////////////////////////////////////////////////
  // axi write side: take address and data in any order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 32'h00000000;
      w_q <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !w_got && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (aw_got && w_got && !s_axi_bvalid)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q[3:0] == `MRD_AXI_STATUS) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // command register; command writes while busy start no access, address and data writes still land
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      go <= 1'b0;
      is_write <= 1'b0;
    end
    else
    begin
      go <= 1'b0;
      if (aw_got && w_got && !s_axi_bvalid)
      begin
        case (aw_q[3:0])
          `MRD_AXI_ADDR: addr_r <= w_q[7:0];
          `MRD_AXI_WDATA: wdata_r <= w_q[7:0];
          `MRD_AXI_CMD:
          begin
            go <= !busy && (w_q[1:0] == `MRD_CMD_READ || w_q[1:0] == `MRD_CMD_WRITE);
            is_write <= w_q[1:0] == `MRD_CMD_WRITE;
          end
          default: ;
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // bus sequencer; chip select wraps the whole strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= MRD_IDLE;
      tick <= 4'h0;
      busy <= 1'b0;
      rdata_r <= 8'h00;
      bus.chip_select_n <= 1'b1;
      bus.read_strobe_n <= 1'b1;
      bus.write_strobe_n <= 1'b1;
      bus.ale <= 1'b0;
      bus.addr <= 8'h00;
      bus.data_h2d <= 8'h00;
      bus.data_h2d_oe <= 1'b0;
    end
    else
    begin
      tick <= tick + 4'h1;
      case (state)
        MRD_IDLE:
          if (go)
          begin
            busy <= 1'b1;
            tick <= 4'h0;
            state <= MRD_SETUP;
            bus.chip_select_n <= 1'b0;
            bus.ale <= 1'b1;
            bus.addr <= addr_r;
            bus.data_h2d <= wdata_r;
            bus.data_h2d_oe <= is_write;
          end
        MRD_SETUP:
          if (tick == PHASE)
          begin
            tick <= 4'h0;
            bus.ale <= 1'b0;
            bus.read_strobe_n <= is_write;
            bus.write_strobe_n <= !is_write;
            state <= MRD_STROBE;
          end
        MRD_STROBE:
          if (tick == PHASE)
          begin
            tick <= 4'h0;
            rdata_r <= bus.data_d2h;
            bus.read_strobe_n <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            state <= MRD_HOLD;
          end
        MRD_HOLD:
          if (tick == PHASE)
          begin
            bus.chip_select_n <= 1'b1;
            bus.data_h2d_oe <= 1'b0;
            state <= MRD_DONE;
          end
        MRD_DONE:
        begin
          busy <= 1'b0;
          state <= MRD_IDLE;
        end
        default: state <= MRD_IDLE;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // axi read side
  always_comb
  begin
    case (s_axi_araddr[3:0])
      `MRD_AXI_ADDR: next_rdata = {24'h000000, addr_r};
      `MRD_AXI_WDATA: next_rdata = {24'h000000, wdata_r};
      `MRD_AXI_STATUS: next_rdata = {23'h000000, busy, rdata_r};
      default: next_rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* mrd_pkg.sv */
// state type of the host end of the register bus
package mrd_pkg;
  typedef enum logic [2:0] {MRD_IDLE, MRD_SETUP, MRD_STROBE, MRD_HOLD, MRD_DONE} mrd_host_state_t;
endpackage

/* tb.sv */
// self-checking bench driving the host end of the register bus over AXI4-Lite
`timescale 1ns/1ps
`include "mrd_consts.svh"
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rate_q;
  logic core_reset_n, standby, counter_load;
  logic [7:0] config_q;
  logic [7:0] loads = 8'h00;
  logic [7:0] l0;
  logic [1:0] r;
  logic [31:0] rd_word;
  int checks = 0;
  int bad_count = 0;
  localparam logic [7:0] ident = {1'b0, `MRD_FAMILY, 1'b0, `MRD_REVISION};
  ////////////////////////////////////////////////////////////////////////////////
  mrd_bus_if bus ();
  mrd_device u_mrd_device (.aclk(aclk), .aresetn(aresetn), .bus(bus),
    .core_reset_n(core_reset_n), .standby(standby), .counter_load(counter_load),
    .config_q(config_q), .rate_q(rate_q));
  mrd_host u_mrd_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus(bus));
  mrd_checker u_mrd_checker (.aclk(aclk), .aresetn(aresetn),
    .chip_select_n(bus.chip_select_n), .read_strobe_n(bus.read_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .data_h2d_oe(bus.data_h2d_oe),
    .data_d2h_oe(bus.data_d2h_oe), .core_reset_n(core_reset_n), .standby(standby),
    .counter_load(counter_load));
  always #25 aclk = ~aclk;
  always @(posedge aclk)
    if (counter_load === 1'b1)
      loads <= loads + 8'h01;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // write address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {28'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= {28'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask
  // busy set on command accept; unknown keeps polling until the watchdog
  task automatic poll(output logic [7:0] d);
    logic [31:0] s;
    s = 32'h00000100;
    while (s[8] !== 1'b0)
      axi_rd(`MRD_AXI_STATUS, s);
    d = s[7:0];
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    axi_wr(`MRD_AXI_ADDR, a);
    axi_wr(`MRD_AXI_WDATA, d);
    axi_wr(`MRD_AXI_CMD, {6'h0, `MRD_CMD_WRITE});
    poll(x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] x;
    axi_wr(`MRD_AXI_ADDR, a);
    axi_wr(`MRD_AXI_CMD, {6'h0, `MRD_CMD_READ});
    poll(x);
    chk(n, e, x);
  endtask
  task automatic hw_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    hw_reset();
    rd_chk(8'h00, ident, "master");
    rd_chk(8'h01, 8'h71, "config");
    rd_chk(8'h03, 8'h03, "rate");
    $display("test reset values done");
    bus_wr(8'h01, 8'h7C);
    rd_chk(8'h01, 8'h7C, "config");
    chk("config_q", 8'h7C, config_q);
    bus_wr(8'h03, 8'hFE);
    rd_chk(8'h03, 8'h02, "rate");
    chk("rate_q", 8'h02, {6'h0, rate_q});
    $display("test read back done");
    l0 = loads;
    bus_wr(8'h00, 8'h7F);
    rd_chk(8'h00, ident, "master");
    chk("loads", 8'h01, loads - l0);
    bus_wr(8'h00, 8'h00);
    rd_chk(8'h00, ident, "master");
    chk("loads", 8'h02, loads - l0);
    $display("test counter load done");
    bus_wr(8'h80, 8'hA5);
    rd_chk(8'h80, 8'hA5, "test reg");
    rd_chk(8'h00, ident, "master");
    rd_chk(8'h81, 8'h00, "test gap");
    rd_chk(8'h07, 8'h00, "reserved");
    $display("test address decode done");
    l0 = loads;
    bus_wr(8'h00, 8'h80);
    chk("standby", 8'h01, {7'h0, standby});
    chk("core_reset_n", 8'h00, {7'h0, core_reset_n});
    rd_chk(8'h00, ident | 8'h80, "master");
    rd_chk(8'h01, 8'h71, "config");
    chk("loads", 8'h00, loads - l0);
    bus_wr(8'h00, 8'h00);
    chk("standby", 8'h00, {7'h0, standby});
    chk("core_reset_n", 8'h01, {7'h0, core_reset_n});
    chk("loads", 8'h01, loads - l0);
    $display("test software reset done");
    bus_wr(8'h00, 8'h80);
    hw_reset();
    rd_chk(8'h00, ident, "master");
    chk("standby", 8'h00, {7'h0, standby});
    axi_wr(`MRD_AXI_STATUS, 8'h00);
    chk("bresp", 8'h02, {6'h0, r});
    axi_wr(`MRD_AXI_ADDR, 8'h5A);
    axi_rd(`MRD_AXI_ADDR, rd_word);
    chk("axi addr", 8'h5A, rd_word[7:0]);
    chk("rresp", 8'h00, {6'h0, rresp});
    axi_wr(`MRD_AXI_CMD, 8'h03);
    axi_rd(`MRD_AXI_STATUS, rd_word);
    chk("bad cmd busy", 8'h00, {7'h0, rd_word[8]});
    $display("test hardware reset done");
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end
endmodule
